// ==== design/pmcs_pkg.sv ====
// Constants, types and decode helpers for the power mode clock select block
`default_nettype none

package pmcs_pkg;

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
    localparam logic [7:0] ADDR_MODE     = 8'h08;
    localparam int         GATE_BIT      = 7;
    localparam int         PRI_FLAG_BIT  = 3;
    localparam int         INT_FLAG_BIT  = 2;
    localparam int         SEC_FLAG_BIT  = 6;
    localparam int         SEL_LSB       = 0;
    localparam int         MODE_BUSY_BIT = 4;
    localparam int         MODE_SRC_LSB  = 8;
    localparam logic       GATE_RESET    = 1'b0;
    localparam logic [1:0] SEL_RESET     = 2'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ          = 50000;
    localparam int POWER_UP_TIMER_MS          = 64;
    localparam int POWER_UP_TIMER_CYCLES      = POWER_UP_TIMER_MS * CLK_KHZ;
    localparam int OST_OSC_CYCLES   = 1024;
    localparam int CPU_READY_NS     = 10000;
    localparam int CPU_READY_CYCLES = (CPU_READY_NS * (CLK_KHZ / 1000)
                                       + 999) / 1000;
    localparam int SW_OLD_TICKS     = 2;
    localparam int SW_NEW_TICKS     = 3;
    localparam int DLY_W            = 22;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_PRI = 2'b00,
        SRC_SEC = 2'b01,
        SRC_INT = 2'b10
    } pmcs_src_t;

    typedef enum logic [1:0] {
        PK_EXT_CLK = 2'b00,
        PK_CRYSTAL = 2'b01,
        PK_INTERNAL_OSCILLATOR  = 2'b10
    } pmcs_prim_t;

    typedef enum logic [2:0] {
        ST_POWER_UP  = 3'b000,
        ST_OSC_START = 3'b001,
        ST_CPU_READY = 3'b010,
        ST_RUN       = 3'b011,
        ST_IDLE      = 3'b100,
        ST_SLEEP     = 3'b101,
        ST_WAKE      = 3'b110
    } pmcs_state_t;

    // Bit index of each vector follows pmcs_src_t encoding
    typedef struct packed {
        logic [2:0] ready;
        logic [2:0] tick;
    } pmcs_osc_t;

    typedef struct packed {
        logic primary_run_mode;
        logic int_stable;
        logic secondary_run_mode;
    } pmcs_flags_t;

    // ------------------------------------------------------------------
    // Select field decode: high bit wins, low bit then ignored
    // ------------------------------------------------------------------
    function automatic pmcs_src_t pmcs_decode_src(input logic [1:0] sel);
        if (sel[1]) begin
            return SRC_INT;
        end
        return sel[0] ? SRC_SEC : SRC_PRI;
    endfunction

endpackage

`default_nettype wire

// ==== design/pmcs_delay.sv ====
// Loadable down counter used for the reset and ready delays
`default_nettype none

module pmcs_delay
    import pmcs_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire logic [DLY_W-1:0] load_val,
    input  wire logic             step,
    output logic                  done
);

    logic [DLY_W-1:0] count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (ce) begin
            if (load) begin
                count_reg <= load_val;
            end else if (step && count_reg != '0) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // A load in flight masks a stale zero
    assign done = (count_reg == '0) && !load;

endmodule

`default_nettype wire

// ==== design/pmcs_clk_mux.sv ====
// Glitch-free source switch producing device clock-enable pulses
`default_nettype none

module pmcs_clk_mux
    import pmcs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic [2:0] tick,
    input  wire logic [2:0] ready,
    input  wire pmcs_src_t  want,
    input  wire logic       allow,
    output pmcs_src_t       cur,
    output logic            busy,
    output logic            pulse
);

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_OLD  = 2'b01,
        PH_NEW  = 2'b10
    } pmcs_phase_t;

    pmcs_phase_t phase_reg;
    pmcs_src_t   cur_reg;
    pmcs_src_t   tgt_reg;
    logic [1:0]  cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= PH_IDLE;
            cur_reg   <= SRC_PRI;
            tgt_reg   <= SRC_PRI;
            cnt_reg   <= 2'h0;
        end else if (ce) begin
            unique case (phase_reg)
                PH_IDLE: begin
                    // Only a running source is switched to
                    if (allow && want != cur_reg && ready[want]) begin
                        tgt_reg   <= want;
                        phase_reg <= PH_OLD;
                        cnt_reg   <= 2'h0;
                    end
                end
                PH_OLD: begin
                    if (tick[cur_reg]) begin
                        if (cnt_reg == 2'(SW_OLD_TICKS - 1)) begin
                            phase_reg <= PH_NEW;
                            cnt_reg   <= 2'h0;
                        end else begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
                PH_NEW: begin
                    if (tick[tgt_reg]) begin
                        if (cnt_reg == 2'(SW_NEW_TICKS - 1)) begin
                            cur_reg   <= tgt_reg;
                            phase_reg <= PH_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
                default: phase_reg <= PH_IDLE;
            endcase
        end
    end

    assign cur  = cur_reg;
    assign busy = (phase_reg != PH_IDLE);
    // Whole old-source pulses only, then silence until the new one settles
    assign pulse = (phase_reg != PH_NEW) && tick[cur_reg];

endmodule

`default_nettype wire

// ==== design/pmcs_top.sv ====
// Power mode sequencing, clock source selection and APB registers
//
// Summary of operation
// - Hold reset for 64 ms power-up timer
// - Crystal modes then wait 1,024 oscillator cycles
// - Ready delay follows power-on before first fetch
// - Gate bit 7, source select bits 1:0
// - Select 00 primary, 01 secondary, 1x internal
// - Select write starts switch if source runs
// - Sleep if gate 0, Idle if 1
// - Run modes clock core and peripherals
// - Gate bit sampled at each sleep instruction
// - Switch: two old, three new cycles
// - Flags at ctrl bits 3, 2; ctrl_b bit 6
// - Flags one-hot by driving clock source, except internal as primary
// - Low-frequency or unstable internal: internal flag zero
// - Internal as primary sets both flags
// - Sleep uses no clock source
// - Slow falling wake pin wakes, even Sleep
// - Sleep, external clock: second pin low
// - Secondary select stops primary, updates flags
// - Sleep stops oscillator, clears all flags
// - Idle left by interrupt, timeout, reset only
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none

module pmcs_top
    import pmcs_pkg::*;
#(
    parameter int POWER_UP_CYCLES = POWER_UP_TIMER_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_exec,
    input  wire logic        wake_req,
    input  wire pmcs_prim_t  primary_kind,
    input  wire logic        internal_oscillator_out_enabled,
    input  wire pmcs_osc_t   osc_pins,
    input  wire logic        int_stable_pin,
    input  wire logic        ultra_low_power_wake,
    output logic             device_reset_n,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic      [2:0]  osc_en,
    output logic             osc2_o,
    output logic             osc2_oe
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 8;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic             ulpw_prev_reg;

    assign pin_raw = {ultra_low_power_wake, int_stable_pin, osc_pins};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else if (ce) begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    pmcs_osc_t osc_s;
    logic      int_stable_s;
    logic      ulpw_s;
    logic      ulpw_fall;

    assign osc_s        = pmcs_osc_t'(sync2_reg[5:0]);
    assign int_stable_s = sync2_reg[6];
    assign ulpw_s       = sync2_reg[7];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ulpw_prev_reg <= 1'b0;
        end else if (ce) begin
            ulpw_prev_reg <= ulpw_s;
        end
    end

    // Falling edge of the slow wake pin counts as a wake event
    assign ulpw_fall = ulpw_prev_reg && !ulpw_s;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic       gate_reg;
    logic [1:0] sel_reg;
    logic       wr_ctrl;
    pmcs_src_t  want_src;

    assign wr_ctrl  = psel && penable && pready && pwrite
                      && paddr == ADDR_CTRL;
    assign want_src = pmcs_decode_src(sel_reg);

    // Wake-ups never touch these bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg <= GATE_RESET;
            sel_reg  <= SEL_RESET;
        end else if (ce && wr_ctrl) begin
            gate_reg <= pwdata[GATE_BIT];
            sel_reg  <= pwdata[SEL_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Power mode sequencer
    // ------------------------------------------------------------------
    pmcs_state_t      state_reg;
    logic             dly_load_reg;
    logic [DLY_W-1:0] dly_val_reg;
    logic             dly_step;
    logic             dly_done;
    pmcs_src_t        cur_src;
    logic             sw_busy;
    logic             dev_pulse;
    logic             mux_allow;
    logic             wake_any;

    assign wake_any  = wake_req || ulpw_fall;
    assign mux_allow = (state_reg == ST_RUN) || (state_reg == ST_IDLE)
                       || (state_reg == ST_WAKE);

    always_comb begin
        unique case (state_reg)
            ST_OSC_START: dly_step = osc_s.tick[SRC_PRI];
            default:      dly_step = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_POWER_UP;
            dly_load_reg <= 1'b1;
            dly_val_reg  <= DLY_W'(POWER_UP_CYCLES);
        end else if (ce) begin
            dly_load_reg <= 1'b0;
            unique case (state_reg)
                ST_POWER_UP: begin
                    if (dly_done) begin
                        dly_load_reg <= 1'b1;
                        if (primary_kind == PK_CRYSTAL) begin
                            state_reg   <= ST_OSC_START;
                            dly_val_reg <= DLY_W'(OST_OSC_CYCLES);
                        end else begin
                            state_reg   <= ST_CPU_READY;
                            dly_val_reg <= DLY_W'(CPU_READY_CYCLES);
                        end
                    end
                end
                ST_OSC_START: begin
                    if (dly_done) begin
                        state_reg    <= ST_CPU_READY;
                        dly_load_reg <= 1'b1;
                        dly_val_reg  <= DLY_W'(CPU_READY_CYCLES);
                    end
                end
                ST_CPU_READY: begin
                    if (dly_done) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Gate bit taken as it stands at this instruction
                    if (sleep_exec) begin
                        state_reg <= gate_reg ? ST_IDLE : ST_SLEEP;
                    end
                end
                ST_IDLE: begin
                    if (wake_any) begin
                        state_reg    <= ST_CPU_READY;
                        dly_load_reg <= 1'b1;
                        dly_val_reg  <= DLY_W'(CPU_READY_CYCLES);
                    end
                end
                ST_SLEEP: begin
                    if (wake_any) begin
                        state_reg <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // No clocks until the selected source is up
                    if (osc_s.ready[want_src] && !sw_busy
                        && cur_src == want_src) begin
                        state_reg    <= ST_CPU_READY;
                        dly_load_reg <= 1'b1;
                        dly_val_reg  <= DLY_W'(CPU_READY_CYCLES);
                    end
                end
                default: state_reg <= ST_POWER_UP;
            endcase
        end
    end

    pmcs_delay u_delay (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .load     (dly_load_reg),
        .load_val (dly_val_reg),
        .step     (dly_step),
        .done     (dly_done)
    );

    pmcs_clk_mux u_mux (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .tick    (osc_s.tick),
        .ready   (osc_s.ready),
        .want    (want_src),
        .allow   (mux_allow),
        .cur     (cur_src),
        .busy    (sw_busy),
        .pulse   (dev_pulse)
    );

    // ------------------------------------------------------------------
    // Clock gating, oscillator enables and pin
    // ------------------------------------------------------------------
    logic       in_sleep;
    logic [2:0] osc_en_next;

    assign in_sleep = (state_reg == ST_SLEEP);

    always_comb begin
        osc_en_next = 3'h0;
        if (!in_sleep) begin
            osc_en_next[cur_src]  = 1'b1;
            osc_en_next[want_src] = 1'b1;
        end
        // Primary runs through the reset delays regardless
        if (state_reg == ST_POWER_UP || state_reg == ST_OSC_START) begin
            osc_en_next[SRC_PRI] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset_n <= 1'b0;
            cpu_clk_en     <= 1'b0;
            periph_clk_en  <= 1'b0;
            osc_en         <= 3'h0;
            osc2_o         <= 1'b0;
            osc2_oe        <= 1'b0;
        end else if (ce) begin
            device_reset_n <= (state_reg != ST_POWER_UP)
                              && (state_reg != ST_OSC_START);
            cpu_clk_en     <= dev_pulse && state_reg == ST_RUN;
            periph_clk_en  <= dev_pulse && (state_reg == ST_RUN
                              || state_reg == ST_IDLE);
            osc_en         <= osc_en_next;
            osc2_o         <= 1'b0;
            // Internal modes leave the pin to port logic
            osc2_oe        <= in_sleep
                              && primary_kind == PK_EXT_CLK;
        end
    end

    // ------------------------------------------------------------------
    // Clock status flags
    // ------------------------------------------------------------------
    pmcs_flags_t flags_reg;
    logic        int_good;

    // Low-frequency source alone gives no stable indication
    assign int_good = int_stable_s && internal_oscillator_out_enabled;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else if (ce) begin
            if (in_sleep || sw_busy) begin
                flags_reg <= '0;
            end else begin
                flags_reg.primary_run_mode    <= cur_src == SRC_PRI;
                flags_reg.secondary_run_mode    <= cur_src == SRC_SEC;
                flags_reg.int_stable <= int_good
                    && (cur_src == SRC_INT
                        || (cur_src == SRC_PRI
                            && primary_kind == PK_INTERNAL_OSCILLATOR));
            end
        end
    end

    // ------------------------------------------------------------------
    // APB slave: no wait states, registered answer
    // ------------------------------------------------------------------
    logic [31:0] rdata_next;
    logic        addr_ok;

    always_comb begin
        rdata_next = 32'h0;
        addr_ok    = 1'b1;
        unique case (paddr)
            ADDR_CTRL: begin
                rdata_next[GATE_BIT]      = gate_reg;
                rdata_next[SEL_LSB +: 2]  = sel_reg;
                rdata_next[PRI_FLAG_BIT]  = flags_reg.primary_run_mode;
                rdata_next[INT_FLAG_BIT]  = flags_reg.int_stable;
            end
            ADDR_CTRL_B: begin
                rdata_next[SEC_FLAG_BIT]  = flags_reg.secondary_run_mode;
            end
            ADDR_MODE: begin
                rdata_next[2:0]           = state_reg;
                rdata_next[MODE_BUSY_BIT] = sw_busy;
                rdata_next[MODE_SRC_LSB +: 2] = cur_src;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !addr_ok;
            // Data only for the access cycle, zero once the answer is taken
            prdata  <= (psel && !penable && !pready && !pwrite)
                       ? rdata_next : 32'h0;
        end
    end

endmodule

`default_nettype wire

// ==== verification/pmcs_top_sva.sv ====
// Port assertions for the power mode clock select block
`default_nettype none

module pmcs_top_sva
    import pmcs_pkg::*;
#(
    parameter int POWER_UP_CYCLES = POWER_UP_TIMER_CYCLES
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        device_reset_n,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic [2:0]  osc_en,
    input wire logic        osc2_o,
    input wire logic        osc2_oe
);
    // ------------------------------------------------------------
    // Held-reset cycle count, assumes ce held high
    // ------------------------------------------------------------
    int up_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 0;
        end else if (!device_reset_n) begin
            up_cnt <= up_cnt + 1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_power_up_timer;
        $rose(device_reset_n) |-> up_cnt >= POWER_UP_CYCLES;
    endproperty
    a_power_up_timer: assert property (p_power_up_timer) else $error("reset released early");

    property p_no_clk_in_reset;
        !device_reset_n |-> !cpu_clk_en && !periph_clk_en;
    endproperty
    a_no_clk_in_reset: assert property (p_no_clk_in_reset)
        else $error("clock enable while held in reset");

    property p_run_both;
        cpu_clk_en |-> periph_clk_en;
    endproperty
    a_run_both: assert property (p_run_both) else $error("core alone");

    property p_sleep_quiet;
        osc2_oe |-> osc_en == 3'h0 && !cpu_clk_en && !periph_clk_en;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("clock activity in sleep");

    property p_osc2_low;
        osc2_oe |-> !osc2_o;
    endproperty
    a_osc2_low: assert property (p_osc2_low) else $error("pin not low");

    property p_zero_wait;
        psel && !penable |=> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("late answer");

    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held");

    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray data");
endmodule

bind pmcs_top pmcs_top_sva #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .device_reset_n(device_reset_n),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .osc2_o(osc2_o), .osc2_oe(osc2_oe)
);

`default_nettype wire

// ==== verification/pmcs_core_model.sv ====
// Behavioural core and oscillator model facing the block
`default_nettype none

module pmcs_core_model
    import pmcs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] osc_en,
    output pmcs_osc_t       osc_pins,
    output logic            sleep_exec
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase;

    initial sleep_exec = 1'b0;

    // ------------------------------------------------------------
    // Oscillators: secondary and internal free-run, primary gated
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase    <= 3'h0;
            osc_pins <= '0;
        end else begin
            phase          <= phase + 3'h1;
            osc_pins.ready <= {2'b11, osc_en[0]};
            osc_pins.tick  <= {phase[1:0] == 2'h2, phase == 3'h3,
                               osc_en[0] && phase[1:0] == 2'h0};
        end
    end

    // One-cycle sleep instruction strobe
    task automatic sleep_cmd();
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== verification/pmcs_top_bench.sv ====
// Self-checking testbench for the power mode clock select block
`default_nettype none

module pmcs_top_bench
    import pmcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        sleep_exec, wake_req, ultra_low_power_wake;
    logic        internal_oscillator_out_enabled, device_reset_n, osc2_o, osc2_oe;
    logic        cpu_clk_en, periph_clk_en, stab;
    pmcs_prim_t  kind;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  osc_en;
    pmcs_osc_t   osc_pins;
    int          fails = 0, comparisons = 0, cyc = 0;

    // Short power-up count keeps the run brief
    pmcs_top #(.POWER_UP_CYCLES(50)) uut (
        .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .wake_req,
        .primary_kind(kind), .internal_oscillator_out_enabled, .osc_pins,
        .int_stable_pin(stab), .ultra_low_power_wake, .device_reset_n,
        .cpu_clk_en, .periph_clk_en, .osc_en, .osc2_o, .osc2_oe
    );
    pmcs_core_model core (.pclk, .presetn, .osc_en, .osc_pins, .sleep_exec);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Primary kind is static, so it only changes under reset
    task automatic reboot(input pmcs_prim_t k);
        @(posedge pclk);
        presetn <= 1'b0;
        kind    <= k;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Poll the mode register; the bench timeout also bounds this
    task automatic wait_mode(input logic [31:0] exp, input logic [31:0] msk);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_MODE, 32'h0);
            n++;
        end while ((rd & msk) !== exp && n < 3000);
        check(rd & msk, exp);
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, wake_req} = 5'h0;
        {paddr, pwdata} = '0;
        ultra_low_power_wake = 1'b1;
        internal_oscillator_out_enabled = 1'b1;
        stab = 1'b1;
        kind = PK_EXT_CLK;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        check(32'({device_reset_n, osc_en}), 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd & 32'h83, 32'h0);
        wait_mode(32'h003, 32'h317);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h08);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_mode(32'h103, 32'h317);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h01);
        apb(1'b0, ADDR_CTRL_B, 32'h0);
        check(rd, 32'h40);
        check(32'(osc_en[0]), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h3);
        wait_mode(32'h203, 32'h317);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h07);
        internal_oscillator_out_enabled <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h03);
        internal_oscillator_out_enabled <= 1'b1;
        stab <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h03);
        stab <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h80);
        wait_mode(32'h003, 32'h317);
        core.sleep_cmd();
        wait_mode(32'h4, 32'h7);
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        wait_mode(32'h3, 32'h7);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h88);
        apb(1'b1, ADDR_CTRL, 32'h0);
        core.sleep_cmd();
        wait_mode(32'h5, 32'h7);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        check(32'({osc2_oe, osc_en}), 32'h8);
        ultra_low_power_wake <= 1'b0;
        wait_mode(32'h3, 32'h7);
        ultra_low_power_wake <= 1'b1;
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        check(32'(er), 32'h1);
        reboot(PK_CRYSTAL);
        repeat (200) @(posedge pclk);
        check(32'(device_reset_n), 32'h0);
        wait_mode(32'h3, 32'h7);
        reboot(PK_INTERNAL_OSCILLATOR);
        wait_mode(32'h3, 32'h7);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0c);
        close_out();
    end
endmodule

`default_nettype wire
